// ==== dmr_pkg.sv ====
package dmr_pkg;

  // Link widths
  localparam int ADDR_W = 14;
  localparam int BA_W   = 3;

  // Bank-address select codes for the four registers
  localparam logic [2:0] BA_MR   = 3'h0;
  localparam logic [2:0] BA_EMR1 = 3'h1;
  localparam logic [2:0] BA_EMR2 = 3'h2;
  localparam logic [2:0] BA_EMR3 = 3'h3;

  // Main mode register fields
  localparam int MR_BL_LSB     = 0;
  localparam int MR_BL_MSB     = 2;
  localparam int MR_BT_BIT     = 3;
  localparam int MR_CL_LSB     = 4;
  localparam int MR_CL_MSB     = 6;
  localparam int MR_TEST_BIT   = 7;
  localparam int MR_DLLRST_BIT = 8;
  localparam int MR_WR_LSB     = 9;
  localparam int MR_WR_MSB     = 11;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;

  // Extended register one fields
  localparam int E1_DLL_DIS_BIT  = 0;
  localparam int E1_HALF_DRV_BIT = 1;
  localparam int E1_RTT0_BIT     = 2;
  localparam int E1_AL_LSB       = 3;
  localparam int E1_AL_MSB       = 5;
  localparam int E1_RTT1_BIT     = 6;
  localparam int E1_CAL_LSB      = 7;
  localparam int E1_CAL_MSB      = 9;
  localparam int E1_DQSN_DIS_BIT = 10;
  localparam int E1_RSTRB_BIT    = 11;
  localparam int E1_QOFF_BIT     = 12;
  localparam logic [2:0] CAL_EXIT    = 3'h0;
  localparam logic [2:0] CAL_DEFAULT = 3'h7;

  // Extended register two fields
  localparam int E2_PAR_LSB     = 0;
  localparam int E2_PAR_MSB     = 2;
  localparam int E2_FAST_SR_BIT = 7;

  // Writable bits; all others are sent as zero
  localparam logic [13:0] MR_MASK   = 14'h0f7f;
  localparam logic [13:0] EMR1_MASK = 14'h1fff;
  localparam logic [13:0] EMR2_MASK = 14'h0087;
  localparam logic [13:0] EMR3_MASK = 14'h0000;
  localparam logic [13:0] REG_RESET = 14'h0000;

  // Timing
  localparam int TCK_NS      = 100;
  localparam int TMRD_CK     = 2;
  localparam int DLL_LOCK_CK = 200;
  localparam int TWR_NS      = 15;
  localparam int WR_MIN_CK   = 2;
  localparam int WR_RAW_CK   = (TWR_NS + TCK_NS - 1) / TCK_NS;
  localparam int WR_CK       = (WR_RAW_CK < WR_MIN_CK) ? WR_MIN_CK : WR_RAW_CK;
  localparam logic [2:0] WR_CODE = 3'(WR_CK - 1);

  // Controller APB map
  localparam logic [7:0] OFF_MR   = 8'h00;
  localparam logic [7:0] OFF_EMR1 = 8'h04;
  localparam logic [7:0] OFF_EMR2 = 8'h08;
  localparam logic [7:0] OFF_EMR3 = 8'h0c;
  localparam logic [7:0] OFF_CMD  = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam int CMD_TGT_LSB  = 0;
  localparam int CMD_TGT_MSB  = 1;
  localparam int CMD_LOAD_BIT = 2;
  localparam int CMD_CKE_BIT  = 3;
  localparam int CMD_SRE_BIT  = 4;
  localparam int CMD_SRX_BIT  = 5;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RDOK_BIT = 1;
  localparam int STAT_CKE_BIT  = 2;
  localparam int STAT_SR_BIT   = 3;
  localparam int STAT_CAL_BIT  = 4;

endpackage

// ==== dmr_link_if.sv ====
`timescale 1ns/10ps
interface dmr_link_if;
  logic        cke;
  logic        csN;
  logic        rasN;
  logic        casN;
  logic        weN;
  logic [2:0]  ba;
  logic [13:0] addr;

  modport ctrl (
    output cke,
    output csN,
    output rasN,
    output casN,
    output weN,
    output ba,
    output addr
  );

  modport mem (
    input cke,
    input csN,
    input rasN,
    input casN,
    input weN,
    input ba,
    input addr
  );
endinterface

// ==== dmr_mem_end.sv ====
`timescale 1ns/10ps
module dmr_mem_end
  import dmr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  dmr_link_if.mem          link,
  input  wire logic        rdActive,
  output logic [13:0]      modeReg_r,
  output logic [13:0]      ext1Reg_r,
  output logic [13:0]      ext2Reg_r,
  output logic [13:0]      ext3Reg_r,
  output logic             burstLen8_r,
  output logic             dllOn_r,
  output logic             dllLocked_r,
  output logic             inSelfRefresh_r,
  output logic             dqOe_r,
  output logic             dqsNOe_r,
  output logic             dmAsStrobe_r
);

  logic       strobesLow;
  logic       loadCmd;
  logic       srEnterCmd;
  logic       srExit;
  logic       dllResetEv;
  logic [7:0] lockCnt_r;
  logic       ckePrev_r;

  // Command decode; clock enable must be high for a load
  assign strobesLow = !link.csN && !link.rasN && !link.casN;
  assign loadCmd    = strobesLow && !link.weN && link.cke && ckePrev_r;
  assign srEnterCmd = strobesLow && link.weN && !link.cke && ckePrev_r;
  assign srExit     = inSelfRefresh_r && link.cke;
  // Main load with bit 8 set, or leaving self-refresh, restarts the loop
  assign dllResetEv = (loadCmd && link.ba == BA_MR && link.addr[MR_DLLRST_BIT])
                      || srExit;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ckePrev_r <= 1'b0;
    end else if (clkEn) begin
      ckePrev_r <= link.cke;
    end
  end

  // Register loads; each replaces the whole word
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      modeReg_r <= REG_RESET;
      ext1Reg_r <= REG_RESET;
      ext2Reg_r <= REG_RESET;
      ext3Reg_r <= REG_RESET;
    end else if (clkEn && loadCmd) begin
      unique case (link.ba)
        BA_MR:   modeReg_r <= link.addr;
        BA_EMR1: ext1Reg_r <= link.addr;
        BA_EMR2: ext2Reg_r <= link.addr;
        BA_EMR3: ext3Reg_r <= link.addr;
        default: ;
      endcase
    end
  end

  // Only codes 4 and 8 change the burst length; others keep the last one
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      burstLen8_r <= 1'b0;
    end else if (clkEn && loadCmd && link.ba == BA_MR) begin
      if (link.addr[MR_BL_MSB:MR_BL_LSB] == BL_CODE_8) begin
        burstLen8_r <= 1'b1;
      end else if (link.addr[MR_BL_MSB:MR_BL_LSB] == BL_CODE_4) begin
        burstLen8_r <= 1'b0;
      end
    end
  end

  // Self-refresh tracking
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      inSelfRefresh_r <= 1'b0;
    end else if (clkEn) begin
      if (srEnterCmd) begin
        inSelfRefresh_r <= 1'b1;
      end else if (srExit) begin
        inSelfRefresh_r <= 1'b0;
      end
    end
  end

  // Loop is off while disabled by bit 0 or in self-refresh
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dllOn_r <= 1'b0;
    end else if (clkEn) begin
      dllOn_r <= !ext1Reg_r[E1_DLL_DIS_BIT] && !inSelfRefresh_r;
    end
  end

  // Lock counter: locked after the settle time from the last reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lockCnt_r   <= 8'h00;
      dllLocked_r <= 1'b0;
    end else if (clkEn) begin
      if (dllResetEv || !dllOn_r) begin
        lockCnt_r   <= 8'h00;
        dllLocked_r <= 1'b0;
      end else if (lockCnt_r == 8'(DLL_LOCK_CK - 1)) begin
        dllLocked_r <= 1'b1;
      end else begin
        lockCnt_r <= lockCnt_r + 8'h01;
      end
    end
  end

  // Output drivers; output-disable keeps them off even during reads
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dqOe_r       <= 1'b0;
      dqsNOe_r     <= 1'b0;
      dmAsStrobe_r <= 1'b0;
    end else if (clkEn) begin
      dqOe_r       <= rdActive && !ext1Reg_r[E1_QOFF_BIT];
      dqsNOe_r     <= rdActive && !ext1Reg_r[E1_QOFF_BIT]
                      && !ext1Reg_r[E1_DQSN_DIS_BIT];
      dmAsStrobe_r <= ext1Reg_r[E1_RSTRB_BIT];
    end
  end

endmodule

// ==== dmr_ctrl_end.sv ====
`timescale 1ns/10ps
module dmr_ctrl_end
  import dmr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata_r,
  output logic             pready_r,
  output logic             pslverr_r,
  input  wire logic        banksIdle,
  input  wire logic        hotCase,
  output logic             readOk_r,
  dmr_link_if.ctrl         link
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GAP  = 2'b01
  } dmr_ctl_state_t;

  dmr_ctl_state_t state_r;
  logic [13:0]    shadow_r [4];
  logic [1:0]     tgt_r;
  logic           loadPend_r;
  logic           calExitPend_r;
  logic           srEnterPend_r;
  logic           srExitPend_r;
  logic           ckeOn_r;
  logic           inSr_r;
  logic [1:0]     gapCnt_r;
  logic [7:0]     lockCnt_r;
  logic           apbDo;
  logic           apbWr;
  logic           cmdWr;
  logic           mapped;
  logic           canIssue;
  logic           issueLoad;
  logic           issueSre;
  logic           issueSrx;
  logic [13:0]    loadWord;
  logic [1:0]     loadTgt;
  logic           dllRstIssue;

  // One wait state: answer in the cycle after the access phase starts
  assign apbDo  = psel && penable && !pready_r;
  // Writes land at the edge that sees pready high, as the master samples it
  assign apbWr  = psel && penable && pready_r && pwrite;
  assign mapped = paddr[1:0] == 2'b00 && paddr <= OFF_STAT;
  assign cmdWr  = apbWr && paddr == OFF_CMD;

  // Loads and self-refresh entry issue only from idle, all banks precharged, enable already high
  assign canIssue  = state_r == ST_IDLE && banksIdle && ckeOn_r && !inSr_r;
  assign issueLoad = canIssue && (loadPend_r || calExitPend_r);
  assign issueSre  = canIssue && !issueLoad && srEnterPend_r;
  assign issueSrx  = state_r == ST_IDLE && inSr_r && srExitPend_r;

  // Word to send: whole shadow with forced fields
  always_comb begin
    loadTgt  = calExitPend_r ? 2'(BA_EMR1) : tgt_r;
    loadWord = shadow_r[loadTgt];
    unique case (loadTgt)
      2'h0: begin
        loadWord[MR_WR_MSB:MR_WR_LSB] = WR_CODE;
        loadWord = loadWord & MR_MASK;
      end
      2'h1: begin
        if (calExitPend_r) begin
          loadWord[E1_CAL_MSB:E1_CAL_LSB] = CAL_EXIT;
        end
      end
      2'h2: begin
        if (hotCase) begin
          loadWord[E2_FAST_SR_BIT] = 1'b1;
        end
      end
      2'h3: loadWord = loadWord & EMR3_MASK;
    endcase
  end

  assign dllRstIssue = (issueLoad && loadTgt == 2'(BA_MR) && loadWord[MR_DLLRST_BIT])
                       || issueSrx;

  // APB answer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else if (clkEn) begin
      pready_r  <= apbDo;
      pslverr_r <= apbDo && !mapped;
      prdata_r  <= 32'h00000000;
      if (apbDo && !pwrite && mapped) begin
        if (paddr == OFF_STAT) begin
          prdata_r[STAT_BUSY_BIT] <= state_r != ST_IDLE || loadPend_r || calExitPend_r;
          prdata_r[STAT_RDOK_BIT] <= readOk_r;
          prdata_r[STAT_CKE_BIT]  <= ckeOn_r;
          prdata_r[STAT_SR_BIT]   <= inSr_r;
          prdata_r[STAT_CAL_BIT]  <= calExitPend_r;
        end else if (paddr == OFF_CMD) begin
          prdata_r[CMD_TGT_MSB:CMD_TGT_LSB] <= tgt_r;
          prdata_r[CMD_LOAD_BIT]            <= loadPend_r;
          prdata_r[CMD_CKE_BIT]             <= ckeOn_r;
        end else begin
          prdata_r[13:0] <= shadow_r[paddr[3:2]];
        end
      end
    end
  end

  // Shadow registers; reserved bits are dropped as they are written
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        shadow_r[i] <= REG_RESET;
      end
    end else if (clkEn && apbWr && paddr <= OFF_EMR3 && paddr[1:0] == 2'b00) begin
      unique case (paddr[3:2])
        2'h0: shadow_r[0] <= pwdata[13:0] & MR_MASK;
        2'h1: shadow_r[1] <= pwdata[13:0] & EMR1_MASK;
        2'h2: shadow_r[2] <= pwdata[13:0] & EMR2_MASK;
        2'h3: shadow_r[3] <= pwdata[13:0] & EMR3_MASK;
      endcase
    end
  end

  // Pending requests; a new request wins over the clear by issue
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tgt_r         <= 2'h0;
      loadPend_r    <= 1'b0;
      calExitPend_r <= 1'b0;
      srEnterPend_r <= 1'b0;
      srExitPend_r  <= 1'b0;
      ckeOn_r       <= 1'b0;
    end else if (clkEn) begin
      if (issueLoad && !calExitPend_r) begin
        loadPend_r <= 1'b0;
      end
      if (issueLoad && calExitPend_r) begin
        calExitPend_r <= 1'b0;
      end else if (issueLoad && loadTgt == 2'(BA_EMR1)
                   && loadWord[E1_CAL_MSB:E1_CAL_LSB] == CAL_DEFAULT) begin
        calExitPend_r <= 1'b1;
      end
      if (issueSre) begin
        srEnterPend_r <= 1'b0;
      end
      if (issueSrx) begin
        srExitPend_r <= 1'b0;
      end
      if (cmdWr) begin
        ckeOn_r <= pwdata[CMD_CKE_BIT];
        if (pwdata[CMD_LOAD_BIT]) begin
          tgt_r      <= pwdata[CMD_TGT_MSB:CMD_TGT_LSB];
          loadPend_r <= 1'b1;
        end
        if (pwdata[CMD_SRE_BIT]) begin
          srEnterPend_r <= 1'b1;
        end
        if (pwdata[CMD_SRX_BIT]) begin
          srExitPend_r <= 1'b1;
        end
      end
    end
  end

  // Sequencer: one command, then the load cycle time as deselect
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r  <= ST_IDLE;
      gapCnt_r <= 2'h0;
      inSr_r   <= 1'b0;
    end else if (clkEn) begin
      unique case (state_r)
        ST_IDLE: begin
          if (issueLoad || issueSre || issueSrx) begin
            state_r  <= ST_GAP;
            // Counts down to one, so the deselect lasts the full cycle time
            gapCnt_r <= 2'(TMRD_CK);
          end
          if (issueSre) begin
            inSr_r <= 1'b1;
          end else if (issueSrx) begin
            inSr_r <= 1'b0;
          end
        end
        ST_GAP: begin
          if (gapCnt_r == 2'h1) begin
            state_r <= ST_IDLE;
          end
          gapCnt_r <= gapCnt_r - 2'h1;
        end
      endcase
    end
  end

  // Link pins, registered
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      link.cke  <= 1'b0;
      link.csN  <= 1'b1;
      link.rasN <= 1'b1;
      link.casN <= 1'b1;
      link.weN  <= 1'b1;
      link.ba   <= 3'h0;
      link.addr <= 14'h0000;
    end else if (clkEn) begin
      link.csN  <= !(issueLoad || issueSre);
      link.rasN <= !(issueLoad || issueSre);
      link.casN <= !(issueLoad || issueSre);
      link.weN  <= !issueLoad;
      link.cke  <= issueSre ? 1'b0 : (issueSrx || (ckeOn_r && !inSr_r));
      if (issueLoad) begin
        link.ba   <= {1'b0, loadTgt};
        link.addr <= loadWord;
      end
    end
  end

  // Read permission after any loop reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lockCnt_r <= 8'h00;
      readOk_r  <= 1'b0;
    end else if (clkEn) begin
      if (dllRstIssue || issueSre) begin
        lockCnt_r <= 8'h00;
        readOk_r  <= 1'b0;
      end else if (lockCnt_r == 8'(DLL_LOCK_CK)) begin
        readOk_r <= !inSr_r;
      end else begin
        lockCnt_r <= lockCnt_r + 8'h01;
      end
    end
  end

endmodule

// ==== dmr_link_assertions.sv ====
`timescale 1ns/10ps
module dmr_link_assertions
  import dmr_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        cke,
  input wire logic        csN,
  input wire logic        rasN,
  input wire logic        casN,
  input wire logic        weN,
  input wire logic [2:0]  ba,
  input wire logic [13:0] addr
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // Load command seen on the pins
  logic ld;
  logic ldMr;
  assign ld = !csN && !rasN && !casN && !weN;
  assign ldMr = ld && ba == BA_MR;

  property p_gap;
    ld |=> csN [*2];
  endproperty
  a_gap: assert property (p_gap)
    else $error("load not followed by two deselect cycles");

  // Clock enable must already be high in the cycle before
  property p_cke;
    ld |-> cke && $past(cke);
  endproperty
  a_cke: assert property (p_cke)
    else $error("load without clock enable held high");

  property p_test;
    ldMr |-> !addr[MR_TEST_BIT];
  endproperty
  a_test: assert property (p_test)
    else $error("test bit set in main load");

  property p_rsvd;
    ldMr |-> (addr & ~MR_MASK) == 14'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved main bits set");

  property p_wr;
    ldMr |-> addr[MR_WR_MSB:MR_WR_LSB] == WR_CODE;
  endproperty
  a_wr: assert property (p_wr)
    else $error("write recovery field wrong");

  property p_e3;
    ld && ba == BA_EMR3 |-> addr == 14'h0000;
  endproperty
  a_e3: assert property (p_e3)
    else $error("extended three data not zero");

  // Default code must be closed by an exit load soon after
  property p_cal;
    ld && ba == BA_EMR1 && addr[E1_CAL_MSB:E1_CAL_LSB] == CAL_DEFAULT
      |-> ##[3:8] (ld && ba == BA_EMR1 && addr[E1_CAL_MSB:E1_CAL_LSB] == CAL_EXIT);
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibration exit load missing");

  property p_ba2;
    ld |-> !ba[2];
  endproperty
  a_ba2: assert property (p_ba2)
    else $error("bank bit 2 high on load");

  c_mr: cover property (ldMr);
  c_cal: cover property (ld && ba == BA_EMR1 && addr[E1_CAL_MSB:E1_CAL_LSB] == CAL_DEFAULT);
  c_e3: cover property (ld && ba == BA_EMR3);
endmodule

// ==== tb_ddr2_mode_register_programming.sv ====
`timescale 1ns/10ps
module tb_ddr2_mode_register_programming
  import dmr_pkg::*;
;
  typedef struct {logic [1:0] t; logic [31:0] d; logic [13:0] e;} dmr_row_t;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        banksIdle = 1'b1;
  logic        hotCase = 1'b0;
  logic        rdActive = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rdData;
  logic        pready;
  logic        pslverr;
  logic        errFlag;
  logic        readOk;
  logic [13:0] memReg [4];
  logic        bl8;
  logic        dllOn;
  logic        dllLocked;
  logic        inSr;
  logic        dqOe;
  logic        dqsNOe;
  logic        dmStrb;
  int          errors = 0;
  int          total_checks = 0;
  int          n;
  // Ordinary loads: target, word written, register expected
  dmr_row_t    rows [6] = '{'{2'd0, 32'hffffe0b3, 14'h0233}, '{2'd0, 32'h00000e4a, 14'h024a},
                            '{2'd1, 32'h00003c7f, 14'h1c7f}, '{2'd2, 32'h00003fff, 14'h0087},
                            '{2'd3, 32'h00003fff, 14'h0000}, '{2'd1, 32'h00000044, 14'h0044}};

  dmr_link_if dmr_link_if_i ();
  dmr_ctrl_end dmr_ctrl_end_i (.ref_clk(ref_clk), .reset_n(reset_n), .clkEn(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_r(prdata), .pready_r(pready), .pslverr_r(pslverr), .banksIdle(banksIdle),
    .hotCase(hotCase), .readOk_r(readOk), .link(dmr_link_if_i));
  dmr_mem_end dmr_mem_end_i (.ref_clk(ref_clk), .reset_n(reset_n), .clkEn(1'b1),
    .link(dmr_link_if_i), .rdActive(rdActive), .modeReg_r(memReg[0]), .ext1Reg_r(memReg[1]),
    .ext2Reg_r(memReg[2]), .ext3Reg_r(memReg[3]), .burstLen8_r(bl8), .dllOn_r(dllOn),
    .dllLocked_r(dllLocked), .inSelfRefresh_r(inSr), .dqOe_r(dqOe), .dqsNOe_r(dqsNOe),
    .dmAsStrobe_r(dmStrb));
  dmr_link_assertions dmr_link_assertions_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .cke(dmr_link_if_i.cke), .csN(dmr_link_if_i.csN), .rasN(dmr_link_if_i.rasN),
    .casN(dmr_link_if_i.casN), .weN(dmr_link_if_i.weN), .ba(dmr_link_if_i.ba),
    .addr(dmr_link_if_i.addr));

  // Free-running 10 MHz clock
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdData = prdata;
    errFlag = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      errors++;
      $display("ERROR apb answer missing");
      end_of_test();
    end
  endtask

  // Poll status until the controller is no longer busy
  task automatic idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, OFF_STAT, 32'h0);
      k++;
    end while (rdData[STAT_BUSY_BIT] !== 1'b0 && k < 40);
    if (k >= 40) begin
      errors++;
      $display("ERROR controller stays busy");
      end_of_test();
    end
  endtask

  // Shadow write, load request with clock enable kept on, then wait
  task automatic ld(input logic [1:0] t, input logic [31:0] d);
    apb(1'b1, {4'h0, t, 2'b00}, d);
    apb(1'b1, OFF_CMD, 32'h0000000c | {30'h0, t});
    idle();
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    rdActive <= 1'b1;
    @(posedge ref_clk);
    chk("mode reg at reset", 32'h0, {18'h0, memReg[0]});
    chk("cke at reset", 32'h0, {31'h0, dmr_link_if_i.cke});
    chk("select at reset", 32'h1, {31'h0, dmr_link_if_i.csN});
    apb(1'b1, OFF_CMD, 32'h00000008);
    foreach (rows[i]) begin
      ld(rows[i].t, rows[i].d);
      chk("loaded reg", {18'h0, rows[i].e}, {18'h0, memReg[rows[i].t]});
      if (rows[i].t != 2'd0) begin
        apb(1'b0, {4'h0, rows[i].t, 2'b00}, 32'h0);
        chk("readback", {18'h0, rows[i].e}, rdData);
      end
    end
    chk("data drive", 32'h1, {31'h0, dqOe});
    chk("complement drive", 32'h1, {31'h0, dqsNOe});
    chk("dll on", 32'h1, {31'h0, dllOn});
    // Output disable, complement off, mask pin as strobe
    ld(2'd1, 32'h00001c00);
    chk("data drive off", 32'h0, {31'h0, dqOe});
    chk("complement off", 32'h0, {31'h0, dqsNOe});
    chk("mask as strobe", 32'h1, {31'h0, dmStrb});
    // Burst codes 4 and 8; other codes leave the length alone
    for (int c = 2; c < 6; c++) begin
      ld(2'd0, 32'(c));
      chk("burst 8", {31'h0, c != 2}, {31'h0, bl8});
    end
    // Calibration default must be followed by the exit code
    ld(2'd1, 32'h00000380);
    chk("cal exit", 32'h0, {18'h0, memReg[1]});
    // Loop reset and read permission delay
    apb(1'b1, OFF_MR, 32'h00000102);
    apb(1'b1, OFF_CMD, 32'h0000000c);
    repeat (4) @(posedge ref_clk);
    chk("locked after reset", 32'h0, {31'h0, dllLocked});
    chk("reads after reset", 32'h0, {31'h0, readOk});
    n = 4;
    while (readOk !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    chk("read wait", 32'h1, {31'h0, n >= 199 && n <= 206});
    repeat (5) @(posedge ref_clk);
    chk("locked", 32'h1, {31'h0, dllLocked});
    // Load held back while banks are open
    banksIdle <= 1'b0;
    apb(1'b1, OFF_MR, 32'h00000003);
    apb(1'b1, OFF_CMD, 32'h0000000c);
    repeat (10) @(posedge ref_clk);
    chk("held load", 32'h0302, {18'h0, memReg[0]});
    banksIdle <= 1'b1;
    idle();
    chk("late load", 32'h0203, {18'h0, memReg[0]});
    // Hot case forces the fast refresh rate bit
    hotCase <= 1'b1;
    ld(2'd2, 32'h00000001);
    chk("fast refresh", 32'h0081, {18'h0, memReg[2]});
    // Self-refresh stops the loop; exit restarts and resets it
    apb(1'b1, OFF_CMD, 32'h00000018);
    idle();
    chk("in self refresh", 32'h1, {31'h0, inSr});
    chk("status self refresh", 32'h1, {31'h0, rdData[STAT_SR_BIT]});
    chk("loop off", 32'h0, {31'h0, dllOn});
    chk("cke low", 32'h0, {31'h0, dmr_link_if_i.cke});
    apb(1'b1, OFF_CMD, 32'h00000028);
    idle();
    chk("out of self refresh", 32'h0, {31'h0, inSr});
    chk("loop on", 32'h1, {31'h0, dllOn});
    chk("loop relock", 32'h0, {31'h0, dllLocked});
    // Unmapped address is refused
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, errFlag});
    chk("unmapped data", 32'h0, rdData);
    // Mid-run reset clears loaded registers and drops the clock enable
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    chk("ext2 after reset", 32'h0, {18'h0, memReg[2]});
    chk("cke after reset", 32'h0, {31'h0, dmr_link_if_i.cke});
    chk("select after reset", 32'h1, {31'h0, dmr_link_if_i.csN});
    end_of_test();
  end
endmodule
